// ===== src/pct_timer.sv
// Postscaled capture timer: 32-bit up/down counter with prescaler, four count
// sources, binary or time-of-day format, postscaler and event capture.
// Assumes a single-cycle register port on mclk; irqSources are on mclk, the
// oscillator and the two pins are asynchronous and are synchronised here.
`timescale 1ns/100ps

// What this block does
// - Read-only 32-bit capture register, reset zero, holds count at enabled event.
// - Writing control bits 31:24 sets postscaler terminal; zero acts as one.
// - Reading control bits 31:24 returns the live postscaler counter.
// - Bit 23 enables the postscaler; timeouts then counted toward interrupts.
// - Read-only bit 19 flags that timeouts reached the postscaler terminal.
// - Bit 18 picks interrupt origin: postscaler match or every timeout.
// - Bit 17 enables event capture.
// - Bits 16:12 pick which of 32 interrupt sources triggers capture.
// - Bits 11:9 pick source: core, low-power oscillator, pin A, pin B.
// - Bit 8 set counts up, clear counts down; down by default.
// - Bit 7 enables counting; disabled at reset.
// - Bit 6 set is periodic, clear is free-running; free-running by default.
// - Bits 5:4 pick binary, 24-hour or 256-hour time format.
// - Bits 3:0 pick prescale divide of 1, 16, 256 or 32768.
// - First assertion of selected source copies count; counting goes on.
// - In periodic mode each overflow reloads the counter from the reload value; free-running wraps.
// - Any write to interrupt clear drops the pending interrupt, unless a new one is raised in the same cycle.
// - In low-power mode counting continues from oscillator or pin sources.
module pct_timer (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic lowPowerOscIn,
  input wire logic extPinA,
  input wire logic extPinB,
  input wire logic lowPowerMode,
  input wire logic [31:0] irqSources,
  output logic timerIrq
);
  import pct_pkg::*;

  typedef struct packed {
    logic [31:0] reload;
    logic [31:0] count;
    logic [31:0] capture;
    logic [7:0] postTerminal;
    logic [7:0] postCount;
    logic postEnable;
    logic compareFlag;
    logic irqFromPost;
    logic captureEnable;
    logic [4:0] eventSel;
    logic [2:0] source;
    logic countUp;
    logic enable;
    logic periodic;
    logic [1:0] format;
    logic [3:0] prescale;
    logic irqPending;
    logic [31:0] rdData;
    logic [1:0] oscSync;
    logic [1:0] pinASync;
    logic [1:0] pinBSync;
    logic oscPrev;
    logic pinAPrev;
    logic pinBPrev;
    logic [31:0] irqPrev;
  } pct_state_type;

  pct_state_type st;
  pct_state_type next_st;

  logic sourceTick;
  logic run;
  logic countTick;
  logic timeout;
  logic postMatch;
  logic captureHit;
  logic [31:0] stepped;
  logic [7:0] hourMax;
  logic [7:0] postTerminalEff;
  logic [31:0] controlRead;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler.
  pct_prescaler u_prescaler (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(run),
    .sourceTick(sourceTick),
    .divideCode(st.prescale),
    .countTick(countTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // One count step in the selected format; the carry out marks a timeout.
  function automatic logic [32:0] pct_step(
    input logic [31:0] value,
    input logic up,
    input logic [1:0] fmt,
    input logic [7:0] hoursMax
  );
    logic [31:0] result;
    logic carry;
    logic [7:0] field;
    logic [7:0] limit;
    result = value;
    carry = 1'b1;
    if (fmt == FMT_HMS_24 || fmt == FMT_HMS_256) begin
      for (int i = 0; i < 4; i++) begin
        field = value[8*i +: 8];
        unique case (i)
          0: limit = HUNDREDTHS_MAX;
          1: limit = SECONDS_MAX;
          2: limit = MINUTES_MAX;
          default: limit = hoursMax;
        endcase
        if (carry) begin
          if (up) begin
            if (field >= limit) begin
              field = 8'h00;
            end else begin
              field = field + 8'h01;
              carry = 1'b0;
            end
          end else begin
            if (field == 8'h00 || field > limit) begin
              field = limit;
            end else begin
              field = field - 8'h01;
              carry = 1'b0;
            end
          end
        end
        result[8*i +: 8] = field;
      end
    end else if (up) begin
      result = value + 32'h00000001;
      carry = (value == 32'hFFFFFFFF);
    end else begin
      result = value - 32'h00000001;
      carry = (value == 32'h00000000);
    end
    return {carry, result};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    next_st = st;

    // Asynchronous sources: the first stage feeds only the second stage.
    next_st.oscSync = {st.oscSync[0], lowPowerOscIn};
    next_st.pinASync = {st.pinASync[0], extPinA};
    next_st.pinBSync = {st.pinBSync[0], extPinB};
    next_st.oscPrev = st.oscSync[1];
    next_st.pinAPrev = st.pinASync[1];
    next_st.pinBPrev = st.pinBSync[1];
    next_st.irqPrev = irqSources;

    unique case (st.source)
      SRC_CORE: sourceTick = !lowPowerMode;
      SRC_LOW_POWER_OSC: sourceTick = st.oscSync[1] && !st.oscPrev;
      SRC_PIN_A: sourceTick = st.pinASync[1] && !st.pinAPrev;
      SRC_PIN_B: sourceTick = st.pinBSync[1] && !st.pinBPrev;
      default: sourceTick = 1'b0;
    endcase
    run = st.enable;

    hourMax = (st.format == FMT_HMS_256) ? HOURS_MAX_256 : HOURS_MAX_24;
    {timeout, stepped} = pct_step(st.count, st.countUp, st.format, hourMax);
    timeout = timeout && countTick;
    if (countTick) begin
      if (timeout && st.periodic) begin
        next_st.count = st.reload;
      end else begin
        next_st.count = stepped;
      end
    end

    // Postscaler: counts timeouts up to the terminal, zero acting as one.
    postTerminalEff = (st.postTerminal == 8'h00) ? POST_TERMINAL_MIN : st.postTerminal;
    postMatch = 1'b0;
    if (!st.postEnable) begin
      next_st.postCount = 8'h00;
    end else if (timeout) begin
      if (st.postCount + 8'h01 >= postTerminalEff) begin
        postMatch = 1'b1;
        next_st.postCount = 8'h00;
      end else begin
        next_st.postCount = st.postCount + 8'h01;
      end
    end

    // Capture on the rising edge of the chosen source; the count runs on.
    captureHit = st.captureEnable && irqSources[st.eventSel] && !st.irqPrev[st.eventSel];
    if (captureHit) begin
      next_st.capture = st.count;
    end

    // Register writes. Reserved bits 22:20 are dropped, so stray ones are harmless.
    if (regWrite) begin
      unique case (regAddr)
        ADDR_RELOAD_VALUE: begin
          next_st.reload = regWrData;
        end
        ADDR_TIMER_CONTROL: begin
          next_st.postTerminal = regWrData[CTL_POST_HI:CTL_POST_LO];
          next_st.postEnable = regWrData[CTL_POST_EN];
          next_st.irqFromPost = regWrData[CTL_IRQ_ORIGIN];
          next_st.captureEnable = regWrData[CTL_CAP_EN];
          next_st.eventSel = regWrData[CTL_EVT_HI:CTL_EVT_LO];
          next_st.source = regWrData[CTL_SRC_HI:CTL_SRC_LO];
          next_st.countUp = regWrData[CTL_UP];
          next_st.enable = regWrData[CTL_ENABLE];
          next_st.periodic = regWrData[CTL_PERIODIC];
          next_st.format = regWrData[CTL_FMT_HI:CTL_FMT_LO];
          next_st.prescale = regWrData[CTL_PRE_HI:CTL_PRE_LO];
        end
        ADDR_INTERRUPT_CLEAR: begin
          next_st.irqPending = 1'b0;
          next_st.compareFlag = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Hardware events are applied after the clear so that a set wins.
    if (postMatch) begin
      next_st.compareFlag = 1'b1;
    end
    if (st.irqFromPost ? postMatch : timeout) begin
      next_st.irqPending = 1'b1;
    end

    controlRead = {st.postCount, st.postEnable, 3'h0, st.compareFlag, st.irqFromPost,
                   st.captureEnable, st.eventSel, st.source, st.countUp, st.enable,
                   st.periodic, st.format, st.prescale};

    // Read data stand only in the cycle after the read strobe.
    next_st.rdData = 32'h00000000;
    if (regRead) begin
      unique case (regAddr)
        ADDR_RELOAD_VALUE: next_st.rdData = st.reload;
        ADDR_CURRENT_COUNT: next_st.rdData = st.count;
        ADDR_TIMER_CONTROL: next_st.rdData = controlRead;
        ADDR_EVENT_CAPTURE: next_st.rdData = st.capture;
        default: next_st.rdData = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.reload <= RELOAD_VALUE_RESET;
      st.count <= CURRENT_COUNT_RESET;
      st.capture <= EVENT_CAPTURE_RESET;
      st.postTerminal <= TIMER_CONTROL_RESET[CTL_POST_HI:CTL_POST_LO];
    end else begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;
  assign timerIrq = st.irqPending;

endmodule

// ===== src/pct_pkg.sv
// Package for the postscaled capture timer: register byte addresses, control
// field positions, reset values, source, format and prescale codes.
// Assumes a 32-bit register port with full byte addresses.
package pct_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [31:0] ADDR_RELOAD_VALUE = 32'hFFFF0320;
  localparam logic [31:0] ADDR_CURRENT_COUNT = 32'hFFFF0324;
  localparam logic [31:0] ADDR_TIMER_CONTROL = 32'hFFFF0328;
  localparam logic [31:0] ADDR_INTERRUPT_CLEAR = 32'hFFFF032C;
  localparam logic [31:0] ADDR_EVENT_CAPTURE = 32'hFFFF0330;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [31:0] TIMER_CONTROL_RESET = 32'h01000000;
  localparam logic [31:0] CURRENT_COUNT_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] RELOAD_VALUE_RESET = 32'h00000000;
  localparam logic [31:0] EVENT_CAPTURE_RESET = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Control field positions.
  localparam int CTL_POST_HI = 31;
  localparam int CTL_POST_LO = 24;
  localparam int CTL_POST_EN = 23;
  localparam int CTL_CMP_FLAG = 19;
  localparam int CTL_IRQ_ORIGIN = 18;
  localparam int CTL_CAP_EN = 17;
  localparam int CTL_EVT_HI = 16;
  localparam int CTL_EVT_LO = 12;
  localparam int CTL_SRC_HI = 11;
  localparam int CTL_SRC_LO = 9;
  localparam int CTL_UP = 8;
  localparam int CTL_ENABLE = 7;
  localparam int CTL_PERIODIC = 6;
  localparam int CTL_FMT_HI = 5;
  localparam int CTL_FMT_LO = 4;
  localparam int CTL_PRE_HI = 3;
  localparam int CTL_PRE_LO = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Count source codes.
  localparam logic [2:0] SRC_CORE = 3'h0;
  localparam logic [2:0] SRC_LOW_POWER_OSC = 3'h1;
  localparam logic [2:0] SRC_PIN_A = 3'h2;
  localparam logic [2:0] SRC_PIN_B = 3'h3;

  // Count format codes; code 1 is reserved and counts as binary.
  localparam logic [1:0] FMT_BINARY = 2'h0;
  localparam logic [1:0] FMT_HMS_24 = 2'h2;
  localparam logic [1:0] FMT_HMS_256 = 2'h3;

  // Prescale codes and the last phase of each divider.
  localparam int PRE_W = 4;
  localparam int PHASE_W = 15;
  localparam logic [3:0] PRE_DIV_1 = 4'h0;
  localparam logic [3:0] PRE_DIV_16 = 4'h4;
  localparam logic [3:0] PRE_DIV_256 = 4'h8;
  localparam logic [3:0] PRE_DIV_32768 = 4'hF;
  localparam logic [14:0] PHASE_LAST_1 = 15'h0000;
  localparam logic [14:0] PHASE_LAST_16 = 15'h000F;
  localparam logic [14:0] PHASE_LAST_256 = 15'h00FF;
  localparam logic [14:0] PHASE_LAST_32768 = 15'h7FFF;

  // Limits of the hours:minutes:seconds:hundredths fields.
  localparam logic [7:0] HUNDREDTHS_MAX = 8'h63;
  localparam logic [7:0] SECONDS_MAX = 8'h3B;
  localparam logic [7:0] MINUTES_MAX = 8'h3B;
  localparam logic [7:0] HOURS_MAX_24 = 8'h17;
  localparam logic [7:0] HOURS_MAX_256 = 8'hFF;

  // Postscaler terminal count used when zero is written.
  localparam logic [7:0] POST_TERMINAL_MIN = 8'h01;

endpackage

// ===== src/pct_prescaler.sv
// Prescaler of the timer: divides the selected source ticks by 1, 16, 256
// or 32768. Assumes sourceTick is a one-cycle pulse on mclk.
`timescale 1ns/100ps

module pct_prescaler (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic sourceTick,
  input wire logic [pct_pkg::PRE_W-1:0] divideCode,
  output logic countTick
);
  import pct_pkg::*;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
  } pct_prescale_state_type;

  pct_prescale_state_type st;
  pct_prescale_state_type next_st;
  logic [PHASE_W-1:0] phaseLast;

  ////////////////////////////////////////////////////////////////////////////
  // Unlisted codes divide by one, so a stray code never stalls the timer.
  always_comb begin
    next_st = st;
    unique case (divideCode)
      PRE_DIV_16: phaseLast = PHASE_LAST_16;
      PRE_DIV_256: phaseLast = PHASE_LAST_256;
      PRE_DIV_32768: phaseLast = PHASE_LAST_32768;
      default: phaseLast = PHASE_LAST_1;
    endcase
    // The >= compare recovers at once when the divide is shortened mid-way.
    countTick = run && sourceTick && (st.phase >= phaseLast);
    if (!run) begin
      next_st.phase = '0;
    end else if (sourceTick) begin
      if (st.phase >= phaseLast) begin
        next_st.phase = '0;
      end else begin
        next_st.phase = st.phase + 15'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ===== testbench/pct_timer_props.sv
// Port-level properties of the postscaled capture timer.
// Assumes it is bound to pct_timer and watches only its register port and interrupt.
`timescale 1ns/100ps

module pct_timer_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic timerIrq
);
  import pct_pkg::*;
  logic [31:0] ctlShadow;
  logic [1:0] idleCount;
  logic ctlRd;
  logic clrWr;
  logic idle;
  logic noPost;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  assign ctlRd = regRead && regAddr == ADDR_TIMER_CONTROL;
  assign clrWr = regWrite && regAddr == ADDR_INTERRUPT_CLEAR;
  assign idle = idleCount == 2'h3;
  assign noPost = ctlShadow[CTL_IRQ_ORIGIN] && !ctlShadow[CTL_POST_EN];

  // The idle count lets a step already in flight at a stop land before clears are judged.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctlShadow <= 32'h0;
      idleCount <= 2'h3;
    end else begin
      if (regWrite && regAddr == ADDR_TIMER_CONTROL) begin
        ctlShadow <= regWrData;
      end
      if (ctlShadow[CTL_ENABLE]) begin
        idleCount <= 2'h0;
      end else if (idleCount != 2'h3) begin
        idleCount <= idleCount + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdData == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_RESERVED_ZERO: assert property (ctlRd |=> regRdData[22:20] == 3'h0)
    else $error("reserved control bits read nonzero");
  AST_CTL_READBACK: assert property (ctlRd |=> regRdData[18:0] == $past(ctlShadow[18:0]))
    else $error("control fields differ from the written word");
  AST_POST_IDLE: assert property (
    ctlRd && !ctlShadow[23] && !$past(ctlShadow[23]) |=> regRdData[31:24] == 8'h0)
    else $error("postscaler counter moved while disabled");
  AST_QUIET_READ: assert property (
    regRead && (regAddr == ADDR_INTERRUPT_CLEAR || regAddr[31:8] != 24'hFFFF03) |=> regRdData == 32'h0)
    else $error("write-only or unmapped read returned data");
  AST_CLR_IRQ: assert property (clrWr && idle |=> !timerIrq)
    else $error("interrupt still pending after a clear");
  // The step that raises the interrupt lies one cycle back, and the timer must have been running then.
  AST_IRQ_NEEDS_RUN: assert property ($rose(timerIrq) |-> $past(ctlShadow[7]))
    else $error("interrupt raised by a stopped timer");
  AST_ORIGIN_NO_POST: assert property ($rose(timerIrq) |-> !($past(noPost, 2) && $past(noPost)))
    else $error("interrupt from a disabled postscaler");
  AST_CLR_FLAG: assert property (clrWr && idle ##2 ctlRd |=> !regRdData[CTL_CMP_FLAG])
    else $error("compare flag survived a clear");

  COV_IRQ: cover property ($rose(timerIrq));
  COV_CTL_READ: cover property (ctlRd);
  COV_IDLE_CLEAR: cover property (clrWr && idle);
endmodule

bind pct_timer pct_timer_props props_i (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .timerIrq(timerIrq));

// ===== testbench/pct_timer_bench.sv
// Self-checking bench for the postscaled capture timer.
// Assumes pct_pkg, pct_timer and its checker are compiled first; the bench drives every port.
`timescale 1ns/100ps

module pct_timer_bench;
  import pct_pkg::*;
  logic mclk, rst_b, regWrite, regRead, lowPowerMode, timerIrq;
  logic [31:0] regAddr, regWrData, regRdData, irqSources, evMask, a, b, c;
  logic [2:0] srcPins;
  logic [31:0] capCtl [5] = '{32'h00025180, 32'h0003F180, 32'h00020180, 32'h00005180, 32'h00025180};
  int capBit [5] = '{5, 31, 0, 5, 6};
  logic [4:0] capHit = 5'b00111;
  int n_mismatch, samples_checked, n;

  pct_timer dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .lowPowerOscIn(srcPins[0]), .extPinA(srcPins[1]),
    .extPinB(srcPins[2]), .lowPowerMode(lowPowerMode), .irqSources(irqSources), .timerIrq(timerIrq));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= adr;
    regWrData <= dat;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  // Event lines are updated with the read strobe so a capture lines up with a count read.
  task automatic rd(input logic [31:0] adr, output logic [31:0] val);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= adr;
    irqSources <= evMask;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 val = regRdData;
  endtask

  task automatic rc(input string what, input logic [31:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    rd(adr, c);
    chk(what, c & mask, exp);
  endtask

  // Two count reads spaced extra+2 cycles apart, or extra+14 with three pin pulses between them if asked.
  task automatic runDiff(input logic [31:0] ctl, input int pin, input int extra, input logic [31:0] exp);
    wr(ADDR_TIMER_CONTROL, ctl);
    rd(ADDR_CURRENT_COUNT, a);
    for (int i = 0; i < 3 && pin >= 0; i++) begin
      srcPins[pin] <= 1'b1;
      repeat (2) @(posedge mclk);
      srcPins[pin] <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    repeat (extra) @(posedge mclk);
    rd(ADDR_CURRENT_COUNT, b);
    chk("count steps", b - a, exp);
    wr(ADDR_TIMER_CONTROL, 32'h0);
  endtask

  task automatic irqWait(input logic [31:0] ctl, input int lo, input int hi);
    wr(ADDR_TIMER_CONTROL, 32'h1C0);
    wr(ADDR_TIMER_CONTROL, ctl);
    wr(ADDR_INTERRUPT_CLEAR, 32'h0);
    #1 n = 0;
    while (timerIrq !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk("cycles to interrupt", 32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    {rst_b, regWrite, regRead, lowPowerMode, srcPins} = '0;
    {regAddr, regWrData, irqSources, evMask} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rc("control reset", ADDR_TIMER_CONTROL, 32'h00FFFFFF, TIMER_CONTROL_RESET & 32'h00FFFFFF);
    rc("count reset", ADDR_CURRENT_COUNT, '1, CURRENT_COUNT_RESET);
    rc("capture reset", ADDR_EVENT_CAPTURE, '1, 32'h0);
    wr(ADDR_CURRENT_COUNT, 32'h0);
    wr(ADDR_EVENT_CAPTURE, 32'h5);
    rc("count read-only", ADDR_CURRENT_COUNT, '1, CURRENT_COUNT_RESET);
    rc("capture read-only", ADDR_EVENT_CAPTURE, '1, 32'h0);
    rc("unmapped", 32'h00001000, '1, 32'h0);
    rc("clear reads", ADDR_INTERRUPT_CLEAR, '1, 32'h0);
    wr(ADDR_TIMER_CONTROL, 32'h0076BE3F);
    rc("control fields", ADDR_TIMER_CONTROL, '1, 32'h0006BE3F);
    wr(ADDR_RELOAD_VALUE, 32'h10);
    rc("reload", ADDR_RELOAD_VALUE, '1, 32'h10);
    wr(ADDR_TIMER_CONTROL, 32'h1C0);
    rd(ADDR_CURRENT_COUNT, a);
    chk("periodic reload", 32'(a >= 32'h10 && a < 32'h20), 32'h1);
    wr(ADDR_TIMER_CONTROL, 32'h080);
    repeat (40) @(posedge mclk);
    rd(ADDR_CURRENT_COUNT, a);
    chk("free-run wrap", 32'(a > 32'hFFFFFF00), 32'h1);
    chk("timeout interrupt", 32'(timerIrq), 32'h1);
    wr(ADDR_TIMER_CONTROL, 32'h0);
    wr(ADDR_INTERRUPT_CLEAR, 32'hA5);
    #1;
    chk("cleared interrupt", 32'(timerIrq), 32'h0);
    runDiff(32'h080, -1, 0, 32'hFFFFFFFE);
    runDiff(32'h180, -1, 0, 32'h2);
    runDiff(32'h184, -1, 30, 32'h2);
    runDiff(32'h188, -1, 510, 32'h2);
    runDiff(32'h18F, -1, 65534, 32'h2);
    runDiff(32'h100, -1, 10, 32'h0);
    lowPowerMode <= 1'b1;
    runDiff(32'h180, -1, 10, 32'h0);
    for (int s = 1; s < 4; s++) begin
      runDiff(32'h180 | (32'(s) << 9), s - 1, 6, 32'h3);
    end
    lowPowerMode <= 1'b0;
    wr(ADDR_RELOAD_VALUE, 32'hFFFFFFFC);
    wr(ADDR_TIMER_CONTROL, 32'h1C0);
    repeat (80) @(posedge mclk);
    irqWait(32'h088401C0, 20, 39);
    wr(ADDR_TIMER_CONTROL, 32'h08840140);
    rd(ADDR_TIMER_CONTROL, a);
    chk("compare flag", 32'(a[CTL_CMP_FLAG]), 32'h1);
    chk("postscaler count", 32'(a[31:24] < 8'h08), 32'h1);
    wr(ADDR_INTERRUPT_CLEAR, 32'h0);
    rc("flag cleared", ADDR_TIMER_CONTROL, 32'h00080000, 32'h0);
    irqWait(32'h008401C0, 0, 8);
    irqWait(32'h088001C0, 0, 8);
    irqWait(32'h000401C0, 40, 40);
    wr(ADDR_RELOAD_VALUE, 32'h0);
    repeat (8) @(posedge mclk);
    wr(ADDR_TIMER_CONTROL, 32'h0A0);
    repeat (30) @(posedge mclk);
    rd(ADDR_CURRENT_COUNT, a);
    chk("hms wrap", {a[31:8], 8'h0}, 32'h173B3B00);
    wr(ADDR_TIMER_CONTROL, 32'h1B0);
    repeat (60) @(posedge mclk);
    rd(ADDR_CURRENT_COUNT, b);
    chk("hms carry", {b[31:8], 8'h0}, 32'h18000000);
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_TIMER_CONTROL, capCtl[k]);
      rd(ADDR_EVENT_CAPTURE, c);
      evMask = 32'h1 << capBit[k];
      rd(ADDR_CURRENT_COUNT, a);
      evMask = 32'h0;
      repeat (5) @(posedge mclk);
      rd(ADDR_EVENT_CAPTURE, b);
      chk("capture", b, capHit[k] ? a : c);
    end
    give_verdict;
  end
endmodule
